// ===== rtl/afc_consts.svh
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH

// Register indexes; byte address is four times the index
`define AFC_IDX_CFG1 8'h00
`define AFC_IDX_TACH_SEL 8'h01
`define AFC_IDX_DAC_SET 8'h04
`define AFC_IDX_PWM_SET 8'h05
`define AFC_IDX_FAN_START_TEMPERATURE_LOC 8'h10
`define AFC_IDX_FAN_START_TEMPERATURE_REM1 8'h11
`define AFC_IDX_FAN_START_TEMPERATURE_REM2 8'h12
`define AFC_IDX_TEST1 8'h14
`define AFC_IDX_STATUS 8'h18

// Field positions
`define AFC_CFG1_MON_EN 0
`define AFC_CFG1_AUTO_DAC 5
`define AFC_CFG1_AUTO_PWM 6
`define AFC_TEST1_PWM_INV 1

// Reset values
`define AFC_RST_CFG1 8'h00
`define AFC_RST_TACH_SEL 8'h00
`define AFC_RST_DAC_SET 8'hff
`define AFC_RST_PWM_SET 8'hff
`define AFC_RST_FAN_START_TEMPERATURE 8'h7f
`define AFC_RST_TEST1 8'h00

// Transfer function figures
`define AFC_RAMP_SPAN 9'h014
`define AFC_HYST_DEG 9'h004
`define AFC_DAC_RAMP_TOP 8'hf0
`define AFC_FULL_SCALE 8'hff
`define AFC_PWM_FLOOR_STEP 8'h11
`define AFC_PWM_PHASE_LAST 8'hfe

// Timing
`define AFC_CLK_HZ 125000000
`define AFC_PWM_FREQ_HZ 75
`define AFC_PWM_STEPS 255
`define AFC_SPINUP_MS 2000
`define AFC_SLOT_CYCLES (`AFC_CLK_HZ / (`AFC_PWM_FREQ_HZ * `AFC_PWM_STEPS))
`define AFC_SPINUP_CYCLES ((`AFC_CLK_HZ / 1000) * `AFC_SPINUP_MS)

// Counter widths and channel count
`define AFC_SLOT_W 13
`define AFC_SPIN_W 28
`define AFC_NCH 3

`endif

// ===== rtl/afc_pkg.sv
`include "afc_consts.svh"

package afc_pkg;

   // Fan state under automatic control
   typedef enum logic [1:0] {FAN_OFF, FAN_SPIN, FAN_RUN} afc_fan_type;

   // Whole state of the controller
   typedef struct packed {
      logic [7:0] cfg1;
      logic [7:0] tach_sel;
      logic [7:0] dac_set;
      logic [7:0] pwm_set;
      logic [`AFC_NCH-1:0][7:0] fan_start_temperature;
      logic [7:0] test1;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      afc_fan_type fan;
      logic [`AFC_SPIN_W-1:0] spin_cnt;
      logic [7:0] dem_dac;
      logic [7:0] dem_pwm;
      logic [`AFC_SLOT_W-1:0] slot_cnt;
      logic [7:0] phase;
      logic [7:0] dac_code;
      logic pwm_oe;
      logic pwm_o;
      logic int_n;
   } afc_state_type;

endpackage : afc_pkg

// ===== rtl/afc_top.sv
`timescale 1ns/1ps
`include "afc_consts.svh"
// Overview of operation
// - Fan DAC code follows the DAC setting register unless automatic control overrides.
// - Power-on reset loads DAC setting with all ones for maximum drive.
// - Open-drain fan pulse output near 75 Hz, duty from PWM setting unless automatic pulse control overrides.
// - Test register bit 1 inverts the pulse output polarity for PMOS drivers.
// - Automatic control runs only while monitoring enable bit 0 is set.
// - Config bits 5 and 6 enable automatic DAC and pulse control separately.
// - Three signed minimum temperature thresholds: local and two remote sensors.
// - Upper nibble D sets floor: DAC 16 times D, duty 6.67 percent times D.
// - With both automatic outputs on, DAC nibble sets both floors; PWM setting ignored.
// - On crossing a threshold, full drive for two seconds, then the highest channel demand.
// - Over 20 degrees drive ramps linearly; duty to 100 percent, DAC to 240.
// - More than 20 degrees above threshold drives the DAC at full scale.
// - Highest demand among the three channels drives the fan outputs.
// - Fan stops only after all channels fall 4 degrees below threshold.
// - Each automatic fan start or stop pulses the active-low interrupt output.
// - Each tach select bit: clear means fan input, set means logic pin.
// - Tach select register resets to zero, all pins fan inputs.
// - Temperatures compared are 8-bit signed values, one degree per step.
module afc_top
   import afc_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES = `AFC_SLOT_CYCLES,
   parameter int unsigned SPINUP_CYCLES = `AFC_SPINUP_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Temperature results from the measurement loop
   input wire logic [7:0] temp_local,
   input wire logic [7:0] temp_remote1,
   input wire logic [7:0] temp_remote2,
   input wire logic temp_valid,
   // Fan drive outputs
   output logic [7:0] dac_code,
   output logic pwm_pin_o,
   output logic pwm_pin_oe,
   input wire logic pwm_pin_i,
   // Tach pin function and interrupt
   output logic [7:0] tach_gpio_sel,
   output logic int_n
);

   afc_state_type cur_ff;
   afc_state_type nxt_st;

   logic [`AFC_NCH-1:0][7:0] temps;
   logic [`AFC_NCH-1:0][7:0] ch_dac;
   logic [`AFC_NCH-1:0][7:0] ch_pwm;
   logic [`AFC_NCH-1:0] ch_hot;
   logic [`AFC_NCH-1:0] ch_cool;
   logic auto_dac;
   logic auto_pwm;
   logic auto_any;
   logic [7:0] dac_floor;
   logic [7:0] pwm_floor;
   logic [3:0] pwm_nib;
   logic [7:0] duty;
   logic [7:0] max_dac;
   logic [7:0] max_pwm;
   logic pulse_high;
   logic [7:0] acc_idx;
   logic acc_ok;
   logic wr_fire;

   // Linear ramp from floor to top over the span
   function automatic logic [7:0] afc_ramp(input logic [7:0] floor_v, input logic [7:0] top_v,
                                           input logic [8:0] delta);
      logic [7:0] diff;
      logic [15:0] prod;
      diff = top_v - floor_v;
      prod = {8'h00, diff} * {7'h00, delta};
      return floor_v + 8'(prod / {7'h00, `AFC_RAMP_SPAN});
   endfunction : afc_ramp

   // Register index decode, shared by read and write paths
   function automatic logic afc_mapped(input logic [7:0] idx);
      case (idx)
         `AFC_IDX_CFG1, `AFC_IDX_TACH_SEL, `AFC_IDX_DAC_SET, `AFC_IDX_PWM_SET,
         `AFC_IDX_FAN_START_TEMPERATURE_LOC, `AFC_IDX_FAN_START_TEMPERATURE_REM1, `AFC_IDX_FAN_START_TEMPERATURE_REM2,
         `AFC_IDX_TEST1, `AFC_IDX_STATUS: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction : afc_mapped

   // Sensor channels in threshold order: local, remote 1, remote 2
   assign temps[0] = temp_local;
   assign temps[1] = temp_remote1;
   assign temps[2] = temp_remote2;

   // Automatic enables, gated by the monitor bit
   assign auto_dac = cur_ff.cfg1[`AFC_CFG1_MON_EN] & cur_ff.cfg1[`AFC_CFG1_AUTO_DAC];
   assign auto_pwm = cur_ff.cfg1[`AFC_CFG1_MON_EN] & cur_ff.cfg1[`AFC_CFG1_AUTO_PWM];
   assign auto_any = auto_dac | auto_pwm;

   // Floors from the upper nibble of the settings
   assign dac_floor = {cur_ff.dac_set[7:4], 4'h0};
   assign pwm_nib = (auto_dac & auto_pwm) ? cur_ff.dac_set[7:4] : cur_ff.pwm_set[7:4];
   // 6.67 percent of 255 steps is 17 steps per nibble count
   assign pwm_floor = 8'({4'h0, pwm_nib} * `AFC_PWM_FLOOR_STEP);

   // Per-channel demand; signed compare of 8-bit degrees
   generate
      for (genvar ch = 0; ch < `AFC_NCH; ch++) begin : g_chan
         logic signed [8:0] delta;
         assign delta = $signed({temps[ch][7], temps[ch]}) -
                        $signed({cur_ff.fan_start_temperature[ch][7], cur_ff.fan_start_temperature[ch]});
         assign ch_hot[ch] = (delta > 9'sd0);
         // Cool only once 4 degrees under the threshold
         assign ch_cool[ch] = (delta <= -$signed(`AFC_HYST_DEG));
         always_comb begin
            if (delta > $signed(`AFC_RAMP_SPAN)) begin
               ch_dac[ch] = `AFC_FULL_SCALE;
               ch_pwm[ch] = `AFC_FULL_SCALE;
            end else if (delta > 9'sd0) begin
               ch_dac[ch] = afc_ramp(dac_floor, `AFC_DAC_RAMP_TOP, delta);
               ch_pwm[ch] = afc_ramp(pwm_floor, `AFC_FULL_SCALE, delta);
            end else begin
               // Inside the hysteresis band the fan idles at its floor
               ch_dac[ch] = dac_floor;
               ch_pwm[ch] = pwm_floor;
            end
         end
      end
   endgenerate

   // Highest demand wins
   always_comb begin
      max_dac = 8'h00;
      max_pwm = 8'h00;
      for (int i = 0; i < `AFC_NCH; i++) begin
         if (ch_dac[i] > max_dac) begin
            max_dac = ch_dac[i];
         end
         if (ch_pwm[i] > max_pwm) begin
            max_pwm = ch_pwm[i];
         end
      end
   end

   // Duty currently applied to the pulse output
   always_comb begin
      if (!auto_pwm) begin
         duty = cur_ff.pwm_set;
      end else begin
         case (cur_ff.fan)
            FAN_OFF: begin
               duty = 8'h00;
            end
            FAN_SPIN: begin
               duty = `AFC_FULL_SCALE;
            end
            FAN_RUN: begin
               duty = cur_ff.dem_pwm;
            end
            default: begin
               duty = 8'h00;
            end
         endcase
      end
   end

   // Phase below duty is the high part unless test1 bit 1 inverts it; full scale never toggles
   assign pulse_high = (cur_ff.phase < duty) ^ cur_ff.test1[`AFC_TEST1_PWM_INV];

   // APB access decode
   assign acc_idx = paddr[9:2];
   assign acc_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && afc_mapped(acc_idx);
   assign wr_fire = psel & penable & cur_ff.pready & pwrite & acc_ok & pstrb[0];

   // Next-state logic
   always_comb begin
      nxt_st = cur_ff;
      nxt_st.int_n = 1'b1;

      // APB: answer one cycle after setup, write lands on the pready edge
      nxt_st.pready = psel & ~penable;
      nxt_st.pslverr = psel & ~penable & ~acc_ok;
      nxt_st.prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite && acc_ok) begin
         case (acc_idx)
            `AFC_IDX_CFG1: begin
               nxt_st.prdata[7:0] = cur_ff.cfg1;
            end
            `AFC_IDX_TACH_SEL: begin
               nxt_st.prdata[7:0] = cur_ff.tach_sel;
            end
            `AFC_IDX_DAC_SET: begin
               nxt_st.prdata[7:0] = cur_ff.dac_set;
            end
            `AFC_IDX_PWM_SET: begin
               nxt_st.prdata[7:0] = cur_ff.pwm_set;
            end
            `AFC_IDX_FAN_START_TEMPERATURE_LOC: begin
               nxt_st.prdata[7:0] = cur_ff.fan_start_temperature[0];
            end
            `AFC_IDX_FAN_START_TEMPERATURE_REM1: begin
               nxt_st.prdata[7:0] = cur_ff.fan_start_temperature[1];
            end
            `AFC_IDX_FAN_START_TEMPERATURE_REM2: begin
               nxt_st.prdata[7:0] = cur_ff.fan_start_temperature[2];
            end
            `AFC_IDX_TEST1: begin
               nxt_st.prdata[7:0] = cur_ff.test1;
            end
            `AFC_IDX_STATUS: begin
               nxt_st.prdata[7:0] = {4'h0, auto_any, pwm_pin_i,
                                     cur_ff.fan == FAN_SPIN, cur_ff.fan != FAN_OFF};
            end
            default: begin
               nxt_st.prdata = 32'h0000_0000;
            end
         endcase
      end
      if (wr_fire) begin
         case (acc_idx)
            `AFC_IDX_CFG1: begin
               nxt_st.cfg1 = pwdata[7:0];
            end
            `AFC_IDX_TACH_SEL: begin
               nxt_st.tach_sel = pwdata[7:0];
            end
            `AFC_IDX_DAC_SET: begin
               nxt_st.dac_set = pwdata[7:0];
            end
            `AFC_IDX_PWM_SET: begin
               nxt_st.pwm_set = pwdata[7:0];
            end
            `AFC_IDX_FAN_START_TEMPERATURE_LOC: begin
               nxt_st.fan_start_temperature[0] = pwdata[7:0];
            end
            `AFC_IDX_FAN_START_TEMPERATURE_REM1: begin
               nxt_st.fan_start_temperature[1] = pwdata[7:0];
            end
            `AFC_IDX_FAN_START_TEMPERATURE_REM2: begin
               nxt_st.fan_start_temperature[2] = pwdata[7:0];
            end
            `AFC_IDX_TEST1: begin
               nxt_st.test1 = pwdata[7:0];
            end
            default: begin
               // Status is read-only
            end
         endcase
      end

      // Demand only moves on a fresh result, so the output stays steady between conversions
      if (temp_valid) begin
         nxt_st.dem_dac = max_dac;
         nxt_st.dem_pwm = max_pwm;
      end

      // Fan state machine
      if (!auto_any) begin
         // Leaving automatic mode is silent; software caused it
         nxt_st.fan = FAN_OFF;
         nxt_st.spin_cnt = '0;
      end else begin
         case (cur_ff.fan)
            FAN_OFF: begin
               if (temp_valid && (ch_hot != '0)) begin
                  nxt_st.fan = FAN_SPIN;
                  nxt_st.spin_cnt = '0;
                  nxt_st.int_n = 1'b0;
               end
            end
            FAN_SPIN: begin
               if (temp_valid && (&ch_cool)) begin
                  nxt_st.fan = FAN_OFF;
                  nxt_st.int_n = 1'b0;
               end else if (cur_ff.spin_cnt == `AFC_SPIN_W'(SPINUP_CYCLES - 1)) begin
                  nxt_st.fan = FAN_RUN;
               end else begin
                  nxt_st.spin_cnt = cur_ff.spin_cnt + 1'b1;
               end
            end
            FAN_RUN: begin
               if (temp_valid && (&ch_cool)) begin
                  nxt_st.fan = FAN_OFF;
                  nxt_st.int_n = 1'b0;
               end
            end
            default: begin
               nxt_st.fan = FAN_OFF;
            end
         endcase
      end

      // Analog output selection
      if (!auto_dac) begin
         nxt_st.dac_code = cur_ff.dac_set;
      end else begin
         case (nxt_st.fan)
            FAN_OFF: begin
               nxt_st.dac_code = 8'h00;
            end
            FAN_SPIN: begin
               nxt_st.dac_code = `AFC_FULL_SCALE;
            end
            FAN_RUN: begin
               nxt_st.dac_code = nxt_st.dem_dac;
            end
            default: begin
               nxt_st.dac_code = 8'h00;
            end
         endcase
      end

      // Pulse timebase: 255 phase steps per period
      if (cur_ff.slot_cnt == `AFC_SLOT_W'(SLOT_CYCLES - 1)) begin
         nxt_st.slot_cnt = '0;
         nxt_st.phase = (cur_ff.phase == `AFC_PWM_PHASE_LAST) ? 8'h00 : cur_ff.phase + 1'b1;
      end else begin
         nxt_st.slot_cnt = cur_ff.slot_cnt + 1'b1;
      end

      // Open drain: high is released, low is driven
      nxt_st.pwm_o = 1'b0;
      nxt_st.pwm_oe = ~pulse_high;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff.cfg1 <= `AFC_RST_CFG1;
         cur_ff.tach_sel <= `AFC_RST_TACH_SEL;
         cur_ff.dac_set <= `AFC_RST_DAC_SET;
         cur_ff.pwm_set <= `AFC_RST_PWM_SET;
         cur_ff.fan_start_temperature <= {`AFC_NCH{`AFC_RST_FAN_START_TEMPERATURE}};
         cur_ff.test1 <= `AFC_RST_TEST1;
         cur_ff.pready <= 1'b0;
         cur_ff.pslverr <= 1'b0;
         cur_ff.prdata <= 32'h0000_0000;
         cur_ff.fan <= FAN_OFF;
         cur_ff.spin_cnt <= '0;
         cur_ff.dem_dac <= 8'h00;
         cur_ff.dem_pwm <= 8'h00;
         cur_ff.slot_cnt <= '0;
         cur_ff.phase <= 8'h00;
         cur_ff.dac_code <= `AFC_RST_DAC_SET;
         cur_ff.pwm_oe <= 1'b0;
         cur_ff.pwm_o <= 1'b0;
         cur_ff.int_n <= 1'b1;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign pready = cur_ff.pready;
   assign prdata = cur_ff.prdata;
   assign pslverr = cur_ff.pslverr;
   assign dac_code = cur_ff.dac_code;
   assign pwm_pin_o = cur_ff.pwm_o;
   assign pwm_pin_oe = cur_ff.pwm_oe;
   assign tach_gpio_sel = cur_ff.tach_sel;
   assign int_n = cur_ff.int_n;

endmodule : afc_top

// ===== verif/afc_checker_assertions.sv
`timescale 1ns/1ps
module afc_checker #(
   parameter int unsigned SLOT_CYCLES = 2,
   parameter int unsigned SPINUP_CYCLES = 20
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Control side
   input wire logic temp_valid,
   input wire logic [7:0] dac_code,
   input wire logic pwm_pin_o,
   input wire logic [7:0] tach_gpio_sel,
   input wire logic int_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Completed write, so register copies may move one or two edges later
   logic wr_done;
   assign wr_done = psel && penable && pwrite && pready;

   a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h00000000)
      else $error("prdata not zero outside access");
   a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("prdata upper bits not zero");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_od_data_low: assert property (pwm_pin_o == 1'b0)
      else $error("open-drain data not low");
   a_int_pulse: assert property ($fell(int_n) |=> int_n)
      else $error("interrupt low longer than one cycle");
   a_int_cause: assert property (!int_n |-> $past(temp_valid))
      else $error("interrupt without a temperature update");
   a_tach_write: assert property ($changed(tach_gpio_sel) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("tach select moved without a write");
   a_spin_full: assert property ($fell(int_n) && dac_code == 8'hff |-> dac_code == 8'hff [*8])
      else $error("spin-up drive dropped early");
endmodule : afc_checker

// ===== verif/afc_fan_model.sv
`timescale 1ns/1ps
// Far-side fan driver: open-drain pin with a pull-up, plus a duty meter
module afc_fan_model (
   // Clock and meter control
   input wire logic pclk,
   input wire logic cnt_clr,
   // Open-drain pin from the block
   input wire logic pwm_pin_o,
   input wire logic pwm_pin_oe,
   // Wire level and measured high time
   output logic pin_level,
   output logic [15:0] high_cnt
);
   // Pull-up wins whenever the block lets go of the pin
   assign pin_level = pwm_pin_oe ? pwm_pin_o : 1'b1;

   // Counts high cycles; one full period gives duty times slot length
   always_ff @(posedge pclk) begin
      if (cnt_clr) begin
         high_cnt <= 16'h0000;
      end else begin
         high_cnt <= high_cnt + {15'h0000, pin_level};
      end
   end
endmodule : afc_fan_model

// ===== verif/test_auto_fan_speed_control.sv
`timescale 1ns/1ps
`include "afc_consts.svh"
module test_auto_fan_speed_control;
   localparam int unsigned SLOT = 2;
   localparam int unsigned SPIN = 20;
   localparam int PERIOD = 255 * SLOT;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, temp_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [7:0] temp_local, temp_remote1, temp_remote2, dac_code, tach_gpio_sel;
   logic pwm_pin_o, pwm_pin_oe, pwm_pin_i, int_n, irq, err_seen, cnt_clr;
   logic [15:0] high_cnt;
   int errors, samples_checked, cycles;

   afc_top #(.SLOT_CYCLES(SLOT), .SPINUP_CYCLES(SPIN)) afc_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .temp_local(temp_local),
      .temp_remote1(temp_remote1), .temp_remote2(temp_remote2), .temp_valid(temp_valid),
      .dac_code(dac_code), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe(pwm_pin_oe), .pwm_pin_i(pwm_pin_i),
      .tach_gpio_sel(tach_gpio_sel), .int_n(int_n));
   afc_fan_model afc_fan_model_i (.pclk(pclk), .cnt_clr(cnt_clr), .pwm_pin_o(pwm_pin_o),
      .pwm_pin_oe(pwm_pin_oe), .pin_level(pwm_pin_i), .high_cnt(high_cnt));

   // Free-running 125 MHz clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task final_report;
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // Hang guard; the whole sequence needs a few thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         final_report();
      end
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask : chk

   // One APB transfer; waits for pready rather than assuming the latency, hang guard ends a stuck wait
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] strb);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h000000, d}, 4'hf);
   endtask : wr

   task rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, idx, 32'h00000000, 4'hf);
      chk(nm, exp, rd);
      chk("pslverr", {31'h0, exp_err}, {31'h0, err_seen});
   endtask : rdc

   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle

   // New temperature set; interrupt level captured in the cycle after
   task tmp(input logic [7:0] l, input logic [7:0] r1, input logic [7:0] r2);
      @(posedge pclk);
      temp_local <= l;
      temp_remote1 <= r1;
      temp_remote2 <= r2;
      temp_valid <= 1'b1;
      @(posedge pclk);
      temp_valid <= 1'b0;
      #1 irq = int_n;
   endtask : tmp

   // Measures exactly one pulse period so phase alignment does not matter
   task duty(input string nm, input logic [15:0] exp);
      repeat (4) @(posedge pclk);
      cnt_clr <= 1'b1;
      @(posedge pclk);
      cnt_clr <= 1'b0;
      repeat (PERIOD) @(posedge pclk);
      #1 chk(nm, {16'h0000, exp}, {16'h0000, high_cnt});
   endtask : duty

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      temp_local = 8'h00;
      temp_remote1 = 8'h00;
      temp_remote2 = 8'h00;
      temp_valid = 1'b0;
      cnt_clr = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk("dac_code", 32'hff, {24'h0, dac_code});
      chk("tach_gpio_sel", 32'h00, {24'h0, tach_gpio_sel});
      rdc("cfg1", `AFC_IDX_CFG1, 32'h00, 1'b0);
      rdc("tach_sel", `AFC_IDX_TACH_SEL, 32'h00, 1'b0);
      rdc("dac_set", `AFC_IDX_DAC_SET, 32'hff, 1'b0);
      rdc("pwm_set", `AFC_IDX_PWM_SET, 32'hff, 1'b0);
      rdc("test1", `AFC_IDX_TEST1, 32'h00, 1'b0);
      for (int i = 0; i < 3; i++) rdc("threshold", 8'(`AFC_IDX_FAN_START_TEMPERATURE_LOC + i), 32'h7f, 1'b0);
      rdc("unmapped", 8'h30, 32'h00, 1'b1);
      // Manual drive, a strobe-less write dropped, tach select
      wr(`AFC_IDX_DAC_SET, 8'h5a);
      apb(1'b1, `AFC_IDX_DAC_SET, 32'h00000033, 4'h0);
      settle();
      chk("dac_code", 32'h5a, {24'h0, dac_code});
      wr(`AFC_IDX_TACH_SEL, 8'ha5);
      settle();
      chk("tach_gpio_sel", 32'ha5, {24'h0, tach_gpio_sel});
      rdc("tach_sel", `AFC_IDX_TACH_SEL, 32'ha5, 1'b0);
      // Manual pulse duty, then inverted polarity
      wr(`AFC_IDX_PWM_SET, 8'h40);
      duty("duty", 16'd128);
      wr(`AFC_IDX_TEST1, 8'h02);
      duty("duty inverted", 16'd382);
      wr(`AFC_IDX_TEST1, 8'h00);
      // Thresholds 30 and 20, third channel parked at 127; monitoring off
      wr(`AFC_IDX_FAN_START_TEMPERATURE_LOC, 8'h1e);
      wr(`AFC_IDX_FAN_START_TEMPERATURE_REM1, 8'h14);
      wr(`AFC_IDX_FAN_START_TEMPERATURE_REM2, 8'h7f);
      wr(`AFC_IDX_DAC_SET, 8'h3c);
      wr(`AFC_IDX_PWM_SET, 8'h00);
      wr(`AFC_IDX_CFG1, 8'h20);
      tmp(8'h28, 8'h1e, 8'hec);
      chk("int_n", 32'h1, {31'h0, irq});
      settle();
      chk("dac_code", 32'h3c, {24'h0, dac_code});
      // Both outputs automatic; negative remote reading must stay cold
      wr(`AFC_IDX_CFG1, 8'h61);
      tmp(8'h28, 8'h0a, 8'hec);
      chk("int_n start", 32'h0, {31'h0, irq});
      chk("dac spin", 32'hff, {24'h0, dac_code});
      // Spinning, running, pin released at full duty, automatic active
      rdc("status", `AFC_IDX_STATUS, 32'h0f, 1'b0);
      repeat (SPIN + 5) @(posedge pclk);
      #1 chk("dac ramp 10", 32'h90, {24'h0, dac_code});
      tmp(8'h32, 8'h0a, 8'hec);
      chk("dac ramp 20", 32'hf0, {24'h0, dac_code});
      tmp(8'h33, 8'h0a, 8'hec);
      chk("dac over 20", 32'hff, {24'h0, dac_code});
      tmp(8'h23, 8'h1e, 8'hec);
      chk("dac highest", 32'h90, {24'h0, dac_code});
      chk("int_n", 32'h1, {31'h0, irq});
      tmp(8'h1b, 8'h11, 8'hec);
      chk("int_n hyst", 32'h1, {31'h0, irq});
      chk("dac floor", 32'h30, {24'h0, dac_code});
      // A hot reading without its valid strobe must not move the drive
      @(posedge pclk);
      temp_local <= 8'h7f;
      settle();
      chk("dac held", 32'h30, {24'h0, dac_code});
      duty("shared floor", 16'd102);
      wr(`AFC_IDX_CFG1, 8'h21);
      duty("pulse manual", 16'd0);
      tmp(8'h1a, 8'h10, 8'hec);
      chk("int_n stop", 32'h0, {31'h0, irq});
      chk("dac off", 32'h00, {24'h0, dac_code});
      final_report();
   end
endmodule : test_auto_fan_speed_control

bind afc_top afc_checker #(.SLOT_CYCLES(SLOT_CYCLES), .SPINUP_CYCLES(SPINUP_CYCLES)) afc_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .temp_valid(temp_valid), .dac_code(dac_code),
   .pwm_pin_o(pwm_pin_o), .tach_gpio_sel(tach_gpio_sel), .int_n(int_n));
